// >>> verilog/tmr_pkg.sv
package tmr_pkg;

   // Register byte offsets on the bus
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_IRQ_FLAGS = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_GEN_CTRL = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_CLK_SEL = 12'h00C;
   localparam logic [ADDR_W-1:0] OFF_CMP_A = 12'h010;

   // Field positions in the enable and flag registers
   localparam int BIT_CMP_A = 1;
   localparam int BIT_OVF = 0;

   // Field positions in the general control register
   localparam int BIT_SYNC = 7;
   localparam int BIT_ASYNC_RST = 1;
   localparam int BIT_SHARED_RST = 0;

   // Clock select fields, one per timer
   localparam int CS_W = 3;
   localparam int CS0_LSB = 0;
   localparam int CS1_LSB = 4;

   // Clock select encodings
   localparam logic [CS_W-1:0] CS_STOP = 3'h0;
   localparam logic [CS_W-1:0] CS_DIRECT = 3'h1;
   localparam logic [CS_W-1:0] CS_DIV8 = 3'h2;
   localparam logic [CS_W-1:0] CS_DIV64 = 3'h3;
   localparam logic [CS_W-1:0] CS_DIV256 = 3'h4;
   localparam logic [CS_W-1:0] CS_DIV1024 = 3'h5;
   localparam logic [CS_W-1:0] CS_EXT_FALL = 3'h6;
   localparam logic [CS_W-1:0] CS_EXT_RISE = 3'h7;

   // Prescaler width and tap widths (divisor = 2**width)
   localparam int PRESC_W = 10;
   localparam int TAP8_W = 3;
   localparam int TAP64_W = 6;
   localparam int TAP256_W = 8;
   localparam int TAP1024_W = 10;

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // Bus answer states
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ANSWER = 2'b01
   } bus_state_t;

   // Requester side of the register bus
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   // Status from the first timer's counter datapath
   typedef struct packed {
      logic [7:0] count_value;
      logic at_max;
      logic bottom_turn;
      logic phase_correct;
   } cnt_status_t;

   // Vector-taken strobes from the interrupt controller
   typedef struct packed {
      logic vec_cmp_a;
      logic vec_ovf;
   } vec_ack_t;

endpackage : tmr_pkg

// >>> verilog/timer_prescaler_irq.sv
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// R01 - Compare IRQ needs enable, global, flag
// R02 - Overflow IRQ needs enable, global, flag
// R03 - Compare flag sets on counter match
// R04 - Compare flag clears on vector or one
// R05 - Overflow flag sets on overflow, clears likewise
// R06 - Phase-correct overflow flag sets at bottom
// R07 - One prescaler, separate select per timer
// R08 - Select one counts every clock
// R09 - Taps at 8, 64, 256, 1024
// R10 - Prescaler free running, first count varies
// R11 - Prescaler reset hits every attached timer
// R12 - Count pin synchronised before edge detect
// R13 - Select 7 rising, 6 falling edges
// R14 - Pin edge to count 2.5-3.5 cycles
// R15 - Switch external source only when pin stable
// R16 - External half period above one cycle
// R17 - External pulses bypass the prescaler
// R18 - Sync mode holds both prescaler resets
// R19 - Clearing sync mode releases both resets
// R20 - Shared reset bit self-clears unless sync
// R21 - Select zero gives no count pulses
// R22 - Unused register bits read zero
module timer_prescaler_irq #(
   parameter int NUM_TIMERS = 2
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // Register bus
   input wire tmr_pkg::apb_req_t APB_REQ,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // First timer's counter and core status
   input wire tmr_pkg::cnt_status_t CNT_STATUS,
   input wire logic GLOBAL_IRQ_ENABLE,
   input wire tmr_pkg::vec_ack_t VEC_ACK,
   // External count pins, one per timer
   input wire logic [NUM_TIMERS-1:0] EXT_COUNT_PIN,
   // Count pulses and interrupt requests
   output logic [NUM_TIMERS-1:0] TIMER_TICK,
   output logic COMPARE_A_IRQ,
   output logic OVERFLOW_IRQ,
   // Prescaler resets, held in sync mode, else one-cycle pulses
   output logic SHARED_PRESCALER_RESET,
   output logic ASYNC_PRESCALER_RESET
);
   import tmr_pkg::*;

   // Whole state of the block
   // One record keeps reset and registering in a single place, so a
   // new field cannot be forgotten in the reset branch
   typedef struct packed {
      bus_state_t bus;                       // Bus answer phase
      logic [31:0] prdata;                   // Read data to master
      logic pready;                          // Answer strobe
      logic pslverr;                         // Unmapped access
      logic cmp_ie;                          // Compare irq enable
      logic ovf_ie;                          // Overflow irq enable
      logic cmp_flag;                        // Compare-match flag
      logic ovf_flag;                        // Overflow flag
      logic sync_mode;                       // Sync mode bit
      logic async_rst;                       // Async prescaler reset
      logic shared_rst;                      // Shared prescaler reset
      logic [NUM_TIMERS-1:0][CS_W-1:0] cs;   // Per-timer clock select
      logic [7:0] cmp_a;                     // Compare value A
      logic [PRESC_W-1:0] presc;             // Shared divider
      logic [NUM_TIMERS-1:0] pin_s1;         // Sync stage one
      logic [NUM_TIMERS-1:0] pin_s2;         // Sync stage two
      logic [NUM_TIMERS-1:0] pin_s3;         // Edge history
      logic [NUM_TIMERS-1:0] tick;           // Count pulses
      logic cmp_irq;                         // Compare request
      logic ovf_irq;                         // Overflow request
   } state_t;

   state_t s_r;    // Registered state
   state_t s_nxt;  // Next state

   // Per-timer count pulse before registering
   // Kept outside the state record, as it is pure logic
   logic [NUM_TIMERS-1:0] tick_nxt;

   // Address decode shared by read and write paths
   // Only the five register addresses hit; anything else answers with an error
   function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
      begin
         is_mapped = (addr == OFF_IRQ_EN) || (addr == OFF_IRQ_FLAGS) ||
            (addr == OFF_GEN_CTRL) || (addr == OFF_CLK_SEL) ||
            (addr == OFF_CMP_A);
      end
   endfunction : is_mapped

   // Count pulse for one timer from its clock select
   // The halt from the shared reset only reaches internal sources; pin
   // edges keep counting, so no external event is lost while it is held
   function automatic logic src_tick(
      input logic [CS_W-1:0] sel,
      input logic [PRESC_W-1:0] presc,
      input logic sync_now,
      input logic sync_old,
      input logic halt
   );
      logic hit;
      begin
         hit = 1'b0;
         case (sel)
            // Stopped: nothing reaches the timer
            CS_STOP: begin
               hit = 1'b0; // R21
            end
            // Undivided system clock
            CS_DIRECT: begin
               hit = 1'b1; // R08
            end
            // Taps fire when the low bits roll over
            CS_DIV8: begin
               hit = &presc[TAP8_W-1:0]; // R09
            end
            // Wider taps fire on a subset of the narrower tap's edges
            CS_DIV64: begin
               hit = &presc[TAP64_W-1:0]; // R09
            end
            CS_DIV256: begin
               hit = &presc[TAP256_W-1:0]; // R09
            end
            CS_DIV1024: begin
               hit = &presc[TAP1024_W-1:0]; // R09
            end
            // External edges go straight through, never divided
            CS_EXT_FALL: begin
               hit = sync_old & ~sync_now; // R13 R17
            end
            // Rising edge: new level high, remembered level low
            CS_EXT_RISE: begin
               hit = sync_now & ~sync_old; // R13 R17
            end
            // All eight codes are listed; this only guards unknown selects
            default: begin
               hit = 1'b0;
            end
         endcase
         // Internal sources stall while the shared reset is held
         if (sel != CS_EXT_FALL && sel != CS_EXT_RISE && halt) begin
            hit = 1'b0; // R18
         end
         src_tick = hit;
      end
   endfunction : src_tick

   // One select field per timer, all fed by the same divider
   // Limitation: a select change while the pin moves may give one false
   // count, so software must switch sources on a quiet pin
   genvar gi;
   generate
      for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_src
         // Edge detect reads only the second and third stages
         assign tick_nxt[gi] = src_tick(s_r.cs[gi], s_r.presc,
            s_r.pin_s2[gi], s_r.pin_s3[gi], s_r.shared_rst); // R07 R12
      end
   endgenerate

   // Next-state logic for bus, registers, flags and divider
   always_comb begin
      logic access;
      logic commit;
      logic wr_hit;
      logic [7:0] wb;
      logic cmp_set;
      logic ovf_set;
      logic cmp_clr;
      logic ovf_clr;
      logic [31:0] rdata;
      logic wr_ie; // Enable register write
      logic wr_flags; // Flag register write
      logic wr_ctrl; // General control write
      logic wr_sel; // Clock select write
      logic wr_cmp; // Compare value write
      // Defaults first, so no path leaves a latch behind
      access = 1'b0;
      commit = 1'b0;
      wr_hit = 1'b0;
      wb = RST_BYTE;
      cmp_set = 1'b0;
      ovf_set = 1'b0;
      cmp_clr = 1'b0;
      ovf_clr = 1'b0;
      rdata = RST_WORD;
      wr_ie = 1'b0;
      wr_flags = 1'b0;
      wr_ctrl = 1'b0;
      wr_sel = 1'b0;
      wr_cmp = 1'b0;
      s_nxt = s_r;

      // Access phase seen by the slave
      access = APB_REQ.psel & APB_REQ.penable;
      // Completing edge: answer is up and master still holds request
      commit = access & (s_r.bus == BUS_ANSWER);
      wr_hit = commit & APB_REQ.pwrite & is_mapped(APB_REQ.paddr);
      wb = APB_REQ.pwdata[7:0];
      // One write strobe per register, decoded once for every user
      wr_ie = wr_hit & (APB_REQ.paddr == OFF_IRQ_EN);
      wr_flags = wr_hit & (APB_REQ.paddr == OFF_IRQ_FLAGS);
      wr_ctrl = wr_hit & (APB_REQ.paddr == OFF_GEN_CTRL);
      wr_sel = wr_hit & (APB_REQ.paddr == OFF_CLK_SEL);
      wr_cmp = wr_hit & (APB_REQ.paddr == OFF_CMP_A);

      // Read mux; unused bits stay zero
      // Reads have no side effects; a flag clears only by writing one or by its vector
      case (APB_REQ.paddr)
         OFF_IRQ_EN: begin
            rdata[BIT_CMP_A] = s_r.cmp_ie; // R22
            rdata[BIT_OVF] = s_r.ovf_ie;
         end
         OFF_IRQ_FLAGS: begin
            rdata[BIT_CMP_A] = s_r.cmp_flag; // R22
            rdata[BIT_OVF] = s_r.ovf_flag;
         end
         OFF_GEN_CTRL: begin
            rdata[BIT_SYNC] = s_r.sync_mode; // R22
            rdata[BIT_ASYNC_RST] = s_r.async_rst;
            rdata[BIT_SHARED_RST] = s_r.shared_rst;
         end
         OFF_CLK_SEL: begin
            // Both select fields share one word, one nibble per timer
            rdata[CS0_LSB +: CS_W] = s_r.cs[0];
            rdata[CS1_LSB +: CS_W] = s_r.cs[1];
         end
         OFF_CMP_A: begin
            // Full byte, every value is a legal compare point
            rdata[7:0] = s_r.cmp_a;
         end
         default: begin
            rdata = RST_WORD;
         end
      endcase

      // Bus answer machine: one wait cycle, then ready for one cycle
      // The fixed wait state costs a cycle per access, but read data then
      // comes from a flip-flop rather than straight from the address
      case (s_r.bus)
         BUS_IDLE: begin
            // Nothing to answer until an access phase shows up
            s_nxt.pready = 1'b0;
            s_nxt.pslverr = 1'b0;
            if (access) begin
               // Latch the answer while address is stable
               s_nxt.bus = BUS_ANSWER;
               s_nxt.pready = 1'b1;
               s_nxt.pslverr = ~is_mapped(APB_REQ.paddr);
               s_nxt.prdata = APB_REQ.pwrite ? RST_WORD : rdata;
            end
         end
         BUS_ANSWER: begin
            // Drop ready so a held request is not taken twice
            s_nxt.bus = BUS_IDLE;
            s_nxt.pready = 1'b0;
            s_nxt.pslverr = 1'b0;
         end
         default: begin
            s_nxt.bus = BUS_IDLE;
            s_nxt.pready = 1'b0;
            s_nxt.pslverr = 1'b0;
         end
      endcase

      // Enable register write; other bits are dropped and read as zero
      if (wr_ie) begin // R22
         s_nxt.cmp_ie = wb[BIT_CMP_A];
         s_nxt.ovf_ie = wb[BIT_OVF];
      end

      // Clock select and compare value writes
      if (wr_sel) begin
         s_nxt.cs[0] = wb[CS0_LSB +: CS_W]; // R07
         s_nxt.cs[1] = wb[CS1_LSB +: CS_W]; // R07
      end
      if (wr_cmp) begin
         s_nxt.cmp_a = wb;
      end

      // Prescaler reset bits: held in sync mode, else one cycle only
      // Hazard: leaving sync mode set with the shared reset bit keeps both timers' internal sources halted for good
      // Writing sync mode to zero drops both resets at the same edge
      if (wr_ctrl) begin
         s_nxt.sync_mode = wb[BIT_SYNC];
         s_nxt.shared_rst = wb[BIT_SHARED_RST]; // R20
         s_nxt.async_rst = wb[BIT_ASYNC_RST];
      end else if (!s_r.sync_mode) begin
         // Sync mode off: both resets fall together
         s_nxt.shared_rst = 1'b0; // R19 R20
         s_nxt.async_rst = 1'b0; // R19
      end else begin
         // Sync mode on: whatever was written stays asserted
         s_nxt.shared_rst = s_r.shared_rst; // R18
         s_nxt.async_rst = s_r.async_rst; // R18
      end

      // Free-running divider; only its own reset bit restarts it
      // A restart shifts the tap phase of every timer on this divider, and
      // the first prescaled count after a select change lags by up to N+1
      if (s_r.shared_rst) begin
         s_nxt.presc = '0; // R11
      end else begin
         s_nxt.presc = s_r.presc + 1'b1; // R10
      end

      // Two-stage synchroniser then one history stage per pin
      // The third stage only keeps the last settled level for edge detect;
      // pin edge to tick takes three edges, so the count lands within 3.5
      s_nxt.pin_s1 = EXT_COUNT_PIN; // R12
      s_nxt.pin_s2 = s_r.pin_s1; // R12 R14
      s_nxt.pin_s3 = s_r.pin_s2; // R14
      s_nxt.tick = tick_nxt; // R14

      // Compare match is judged on the first timer's count pulse
      // Events are judged on the registered tick, in the same cycle it leaves on TIMER_TICK
      cmp_set = s_r.tick[0] &
         (CNT_STATUS.count_value == s_r.cmp_a); // R03
      // Overflow at max, or at bottom turn in phase-correct mode
      // In phase-correct mode the top is never an overflow
      if (CNT_STATUS.phase_correct) begin
         ovf_set = s_r.tick[0] & CNT_STATUS.bottom_turn; // R06
      end else begin
         ovf_set = s_r.tick[0] & CNT_STATUS.at_max; // R05
      end

      // Clear by vector or by writing one; zero has no effect
      // Writing zero leaves a flag alone, so other flags are safe
      cmp_clr = VEC_ACK.vec_cmp_a |
         (wr_flags & wb[BIT_CMP_A]); // R04
      ovf_clr = VEC_ACK.vec_ovf |
         (wr_flags & wb[BIT_OVF]); // R05

      // A set in the clearing cycle wins, so no event is lost
      // The price: a clear that meets a new event leaves the flag set
      s_nxt.cmp_flag = (s_r.cmp_flag & ~cmp_clr) | cmp_set; // R03 R04
      s_nxt.ovf_flag = (s_r.ovf_flag & ~ovf_clr) | ovf_set; // R05

      // Requests need enable, global enable and flag together
      // Built from next values, so a request falls at the edge its flag clears
      s_nxt.cmp_irq = s_nxt.cmp_ie & GLOBAL_IRQ_ENABLE &
         s_nxt.cmp_flag; // R01
      s_nxt.ovf_irq = s_nxt.ovf_ie & GLOBAL_IRQ_ENABLE &
         s_nxt.ovf_flag; // R02
   end

   // State register; synchronous reset to idle and zero
   // Reset is synchronous, so the clock must run while it is held
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         s_r <= '0;
         // Idle is written by name in case its code ever changes
         s_r.bus <= BUS_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   // No logic between flip-flop and pin, so outputs cannot glitch
   assign PRDATA = s_r.prdata;
   assign PREADY = s_r.pready;
   assign PSLVERR = s_r.pslverr;
   assign TIMER_TICK = s_r.tick;
   assign COMPARE_A_IRQ = s_r.cmp_irq;
   assign OVERFLOW_IRQ = s_r.ovf_irq;
   // Reset levels, held only in sync mode, go out for the second timer and async divider
   assign SHARED_PRESCALER_RESET = s_r.shared_rst;
   assign ASYNC_PRESCALER_RESET = s_r.async_rst;

endmodule : timer_prescaler_irq

// >>> verification/tmr_properties.sv
`timescale 1ns/1ps
module tmr_checker #(
   parameter int NUM_TIMERS = 2
) (
   // Clock, reset and bus
   input wire logic REF_CLK,
   input wire logic RST,
   input wire tmr_pkg::apb_req_t APB_REQ,
   input wire logic PREADY,
   // Core status and pins
   input wire logic GLOBAL_IRQ_ENABLE,
   input wire logic [NUM_TIMERS-1:0] EXT_COUNT_PIN,
   // Watched outputs
   input wire logic [NUM_TIMERS-1:0] TIMER_TICK,
   input wire logic COMPARE_A_IRQ,
   input wire logic OVERFLOW_IRQ,
   input wire logic SHARED_PRESCALER_RESET,
   input wire logic ASYNC_PRESCALER_RESET
);
   import tmr_pkg::*;
   logic commit; // Write taking effect at this edge
   logic [CS_W-1:0] sel0_r; // Shadow of timer0 select
   logic [CS_W-1:0] sel1_r; // Shadow of timer1 select
   logic sync_r; // Shadow of sync mode
   assign commit = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && PREADY;
   // Shadows follow committed writes only, as the block does
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         sel0_r <= CS_STOP;
         sel1_r <= CS_STOP;
         sync_r <= 1'h0;
      end else if (commit && APB_REQ.paddr == OFF_CLK_SEL) begin
         sel0_r <= APB_REQ.pwdata[CS0_LSB +: CS_W];
         sel1_r <= APB_REQ.pwdata[CS1_LSB +: CS_W];
      end else if (commit && APB_REQ.paddr == OFF_GEN_CTRL) begin
         sync_r <= APB_REQ.pwdata[BIT_SYNC];
      end
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   AST_CMP_IRQ_GATE: assert property (COMPARE_A_IRQ |-> $past(GLOBAL_IRQ_ENABLE))
      else $error("compare irq without global enable");
   AST_OVF_IRQ_GATE: assert property (OVERFLOW_IRQ |-> $past(GLOBAL_IRQ_ENABLE))
      else $error("overflow irq without global enable");
   AST_STOP_NO_TICK: assert property ($past(sel0_r) == CS_STOP |-> !TIMER_TICK[0])
      else $error("tick while stopped");
   AST_DIRECT_TICK: assert property ($past(sel0_r) == CS_DIRECT &&
      !$past(SHARED_PRESCALER_RESET) |-> TIMER_TICK[0]) else $error("direct tick missing");
   AST_DIV8_GAP: assert property (TIMER_TICK[0] && sel0_r == CS_DIV8
      && $past(sel0_r) == CS_DIV8 |=> !TIMER_TICK[0] [*7]) else $error("div8 too fast");
   AST_EXT_RISE: assert property ($rose(EXT_COUNT_PIN[0]) && sel0_r == CS_EXT_RISE
      |-> ##3 TIMER_TICK[0]) else $error("rising edge tick late");
   AST_EXT_FALL: assert property ($fell(EXT_COUNT_PIN[1]) && sel1_r == CS_EXT_FALL
      |-> ##3 TIMER_TICK[1]) else $error("falling edge tick late");
   AST_SHARED_PULSE: assert property ($rose(SHARED_PRESCALER_RESET) && !sync_r
      |=> !SHARED_PRESCALER_RESET) else $error("shared reset not cleared");
   AST_SYNC_RELEASE: assert property ($fell(sync_r)
      |=> !SHARED_PRESCALER_RESET && !ASYNC_PRESCALER_RESET) else $error("resets held");
   cover property (COMPARE_A_IRQ);
   cover property (OVERFLOW_IRQ);
   cover property (TIMER_TICK[0] && sel0_r == CS_EXT_RISE);
   cover property (TIMER_TICK[1] && sel1_r == CS_EXT_FALL);
endmodule : tmr_checker

bind timer_prescaler_irq tmr_checker #(.NUM_TIMERS(NUM_TIMERS)) u_chk (
   .REF_CLK(REF_CLK), .RST(RST), .APB_REQ(APB_REQ), .PREADY(PREADY),
   .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .EXT_COUNT_PIN(EXT_COUNT_PIN),
   .TIMER_TICK(TIMER_TICK), .COMPARE_A_IRQ(COMPARE_A_IRQ), .OVERFLOW_IRQ(OVERFLOW_IRQ),
   .SHARED_PRESCALER_RESET(SHARED_PRESCALER_RESET),
   .ASYNC_PRESCALER_RESET(ASYNC_PRESCALER_RESET)
);

// >>> verification/ext_pin_src.sv
`timescale 1ns/1ps
module ext_pin_src (
   // Clock and control
   input wire logic REF_CLK,
   input wire logic run,
   input wire logic [3:0] half,
   // Pin and edge tallies
   output logic pin,
   output int rises,
   output int falls
);
   int cnt_r; // Cycles into this half period
   initial begin
      pin = 1'h0;
      cnt_r = 0;
      rises = 0;
      falls = 0;
   end
   // Pin stands still when stopped, so selects change only on a quiet pin
   always @(posedge REF_CLK) begin
      if (run && cnt_r + 1 >= half) begin
         pin <= !pin;
         rises <= rises + (pin ? 0 : 1);
         falls <= falls + (pin ? 1 : 0);
         cnt_r <= 0;
      end else begin
         cnt_r <= run ? cnt_r + 1 : 0;
      end
   end
endmodule : ext_pin_src

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
   import tmr_pkg::*;
   logic REF_CLK = 1'h0;
   logic RST = 1'h1;
   apb_req_t req = '0; // Bus request
   cnt_status_t st = {8'h11, 3'h0}; // Counter status, idle
   vec_ack_t vec = '0;
   logic gie = 1'h0;
   logic run = 1'h0;
   logic [3:0] half = 4'h2;
   logic pin, pready, pslverr, cirq, oirq, srst, arst;
   logic [31:0] prdata;
   logic [1:0] tick;
   int rises, falls, a0, a1, r0, f0;
   int tk0 = 0;
   int tk1 = 0;
   int error_cnt = 0;
   int checked = 0;
   int exp_t[6] = '{0, 2048, 256, 32, 8, 2}; // Ticks per 2048 cycles
   always #12.5 REF_CLK = ~REF_CLK;
   timer_prescaler_irq u_dut (.REF_CLK(REF_CLK), .RST(RST), .APB_REQ(req),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CNT_STATUS(st),
      .GLOBAL_IRQ_ENABLE(gie), .VEC_ACK(vec), .EXT_COUNT_PIN({pin, pin}),
      .TIMER_TICK(tick), .COMPARE_A_IRQ(cirq), .OVERFLOW_IRQ(oirq),
      .SHARED_PRESCALER_RESET(srst), .ASYNC_PRESCALER_RESET(arst));
   ext_pin_src u_src (.REF_CLK(REF_CLK), .run(run), .half(half), .pin(pin),
      .rises(rises), .falls(falls));
   // Tick tallies, updated late so snapshots never race them
   always @(posedge REF_CLK) begin
      tk0 <= tk0 + ((tick[0] === 1'h1) ? 1 : 0);
      tk1 <= tk1 + ((tick[1] === 1'h1) ? 1 : 0);
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   // One transfer; request held until PREADY is seen at an edge
   // Waits as long as it takes; only the watchdog ends a hang
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      req <= '{1'h1, 1'h0, w, a, d};
      @(posedge REF_CLK);
      req.penable <= 1'h1;
      do begin
         @(posedge REF_CLK);
      end while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      req <= '0;
      @(posedge REF_CLK);
   endtask : apb
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'h1, a, d, q, e);
   endtask : wr
   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'h0, a, 32'h0, q, e);
      chk($sformatf("read %h", a), exp, q);
   endtask : rdc
   // One-cycle status or vector event, then idle
   task automatic pulse(input cnt_status_t s, input vec_ack_t v);
      st <= s;
      vec <= v;
      @(posedge REF_CLK);
      st <= {8'h11, 3'h0};
      vec <= '0;
      repeat (2) @(posedge REF_CLK);
   endtask : pulse
   task automatic wrap_up();
      $display("checked %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up
   // Watchdog sized well above the whole sequence
   initial begin
      #1000000;
      error_cnt++;
      wrap_up();
   end
   initial begin
      logic [31:0] q;
      logic e;
      repeat (6) @(posedge REF_CLK);
      RST <= 1'h0;
      @(posedge REF_CLK);
      for (int a = 0; a <= 16; a += 4) rdc(12'(a), 32'h0);
      apb(1'h0, 12'h020, 32'h0, q, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      $display("test reset done");
      wr(OFF_GEN_CTRL, 32'hFF);
      rdc(OFF_GEN_CTRL, 32'h83);
      chk("held resets", 32'h3, {30'h0, srst, arst});
      wr(OFF_CLK_SEL, 32'h22);
      a0 = tk0;
      a1 = tk1;
      repeat (64) @(posedge REF_CLK);
      chk("halted", 32'h0, 32'(tk0 - a0 + tk1 - a1));
      wr(OFF_GEN_CTRL, 32'h0);
      chk("released", 32'h0, {30'h0, srst, arst});
      wr(OFF_GEN_CTRL, 32'h1);
      rdc(OFF_GEN_CTRL, 32'h0);
      $display("test control done");
      for (int s = 0; s < 6; s++) begin
         wr(OFF_CLK_SEL, 32'({3'(5 - s), 4'(s)}));
         repeat (2) @(posedge REF_CLK);
         a0 = tk0;
         a1 = tk1;
         repeat (2048) @(posedge REF_CLK);
         chk("timer0 ticks", 32'(exp_t[s]), 32'(tk0 - a0));
         chk("timer1 ticks", 32'(exp_t[5 - s]), 32'(tk1 - a1));
      end
      $display("test prescaler done");
      wr(OFF_CLK_SEL, 32'h67);
      for (int h = 2; h <= 5; h += 3) begin
         repeat (8) @(posedge REF_CLK);
         a0 = tk0;
         a1 = tk1;
         r0 = rises;
         f0 = falls;
         half <= 4'(h);
         run <= 1'h1;
         repeat (60) @(posedge REF_CLK);
         run <= 1'h0;
         repeat (8) @(posedge REF_CLK);
         chk("rise ticks", 32'(rises - r0), 32'(tk0 - a0));
         chk("fall ticks", 32'(falls - f0), 32'(tk1 - a1));
      end
      $display("test external done");
      wr(OFF_CMP_A, 32'h40);
      wr(OFF_CLK_SEL, 32'h1);
      wr(OFF_IRQ_EN, 32'hFF);
      rdc(OFF_IRQ_EN, 32'h3);
      gie <= 1'h1;
      pulse({8'h40, 3'h0}, '0);
      rdc(OFF_IRQ_FLAGS, 32'h2);
      chk("cmp irq", 32'h1, {31'h0, cirq});
      gie <= 1'h0;
      repeat (2) @(posedge REF_CLK);
      chk("cmp irq off", 32'h0, {31'h0, cirq});
      wr(OFF_IRQ_FLAGS, 32'h0);
      rdc(OFF_IRQ_FLAGS, 32'h2);
      wr(OFF_IRQ_FLAGS, 32'h2);
      rdc(OFF_IRQ_FLAGS, 32'h0);
      pulse({8'h11, 3'h4}, '0);
      gie <= 1'h1;
      repeat (2) @(posedge REF_CLK);
      chk("ovf irq", 32'h1, {31'h0, oirq});
      wr(OFF_IRQ_EN, 32'h2);
      chk("ovf irq masked", 32'h0, {31'h0, oirq});
      pulse({8'h11, 3'h0}, 2'h1);
      rdc(OFF_IRQ_FLAGS, 32'h0);
      pulse({8'h11, 3'h3}, '0);
      pulse({8'h40, 3'h0}, '0);
      pulse({8'h11, 3'h0}, 2'h2);
      rdc(OFF_IRQ_FLAGS, 32'h1);
      $display("test flags done");
      wrap_up();
   end
endmodule : tb
